// ==== rtl/rss_ctl_if.sv ====
// Control and event signals between the supervisor and its two timers.
// Assumes all three modules share the system clock.
interface rss_ctl_if;
    logic sys_rst;
    logic wdt_enable;
    logic wdt_kick;
    logic wdt_fire;
    logic loss_enable;
    logic clk_edge;
    logic loss_fire;

    modport ctl_mp (
        output sys_rst, wdt_enable, wdt_kick, loss_enable, clk_edge,
        input wdt_fire, loss_fire
    );
    modport wdt_mp (
        input sys_rst, wdt_enable, wdt_kick,
        output wdt_fire
    );
    modport loss_mp (
        input loss_enable, clk_edge,
        output loss_fire
    );
endinterface : rss_ctl_if

// ==== rtl/rss_loss_det.sv ====
// Clock-loss one-shot: retriggered by each edge of the watched clock.
// Assumes clk_edge is already synchronised to the system clock.
module rss_loss_det
    import rss_pkg::*;
#(
    parameter int TIMEOUT = LOSS_TIMEOUT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    rss_ctl_if.loss_mp ctl
);
    localparam int CW = $clog2(TIMEOUT + 1);

    generate
        if (TIMEOUT < 1) begin : g_bad
            $error("rss_loss_det: TIMEOUT must be >= 1");
        end
    endgenerate

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic fire_reg;
    wire full = (cnt_reg == CW'(TIMEOUT));
    wire retrig = ctl.clk_edge | ~ctl.loss_enable;

    assign cnt_next = retrig ? '0 : (full ? cnt_reg : cnt_reg + 1'b1);
    assign ctl.loss_fire = fire_reg;

    // The request stays up for as long as the clock stays stuck.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            fire_reg <= 1'b0;
        end else if (ce_i) begin
            cnt_reg <= cnt_next;
            fire_reg <= ~retrig & (cnt_next == CW'(TIMEOUT));
        end
    end
endmodule : rss_loss_det

// ==== rtl/rss_pkg.sv ====
// Shared constants and types for the reset source supervisor.
// Assumes a single 20 MHz system clock and an 8-bit special register port.
package rss_pkg;

    // ------------------------------------------------------------------
    // Register addresses and bit positions
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_SUPPLY_CTRL = 8'hFF;
    localparam logic [7:0] ADDR_RESET_SRC = 8'hEF;
    localparam logic [7:0] ADDR_WDT_CTRL = 8'hD9;

    localparam int SMC_EN_BIT = 7;
    localparam int SMC_STAT_BIT = 6;
    localparam int RSR_PIN_BIT = 0;
    localparam int RSR_POR_BIT = 1;
    localparam int RSR_LOSS_BIT = 2;
    localparam int RSR_SOFT_BIT = 4;
    localparam int RSR_WDT_BIT = 5;
    localparam int WDC_EN_BIT = 0;
    localparam int WDC_KICK_BIT = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic SMC_EN_RESET = 1'b1;
    localparam logic MON_SEL_RESET = 1'b1;
    localparam logic LOSS_EN_RESET = 1'b0;
    localparam logic WDT_EN_RESET = 1'b1;
    localparam logic [7:0] RD_ZERO = 8'h00;
    localparam logic [5:0] FLAGS_RESET = 6'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int LOSS_TIMEOUT_NS = 500;
    localparam int LOSS_TIMEOUT_CYC = LOSS_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int HOLD_NS = 200;
    localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WDT_DIV = 12;
    localparam int WDT_LIMIT = 255;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic {
        ST_RUN = 1'b0,
        ST_HOLD = 1'b1
    } rss_state_t;

    typedef enum logic [2:0] {
        CAUSE_POWER = 3'b000,
        CAUSE_PIN = 3'b001,
        CAUSE_SUPPLY = 3'b010,
        CAUSE_LOSS = 3'b011,
        CAUSE_WDT = 3'b100,
        CAUSE_SOFT = 3'b101
    } rss_cause_t;

endpackage : rss_pkg

// ==== rtl/rss_supervisor.sv ====
// Reset source supervisor: supply monitor control, reset pin, clock-loss
// and watchdog resets, and the reset-source flags.
// Assumes RESET_N_I is the power-on reset and the processor sits behind
// the special register port; pins and the comparator are asynchronous.
//
// Summary of operation
// - Monitor control bit 7 turns the supply monitor on or off.
// - Supply resets only when monitor enabled and selected as source.
// - Monitor control bit 6 shows the live supply comparator output.
// - Bits 5 to 0 of monitor control ignore writes.
// - A low level on the reset pin requests a reset.
// - Source bit 0 is set on leaving a pin reset.
// - Clock-loss one-shot resets when the watched clock stops toggling.
// - Source bit 2 reads 1 only after a clock-loss reset.
// - Writing source bit 2 enables or disables the clock-loss detector.
// - Clock-loss and watchdog resets leave the reset pin undriven.
// - Every reset leaves the watchdog enabled on the clock divided by 12.
// - A watchdog timeout resets and sets source bit 5.
// - Monitor enable is set by power-on only and survives other resets.
// - Low supply holds reset and drives the pin low until it recovers.
// - Writing 1 to source bit 1 selects the monitor as reset source.
module rss_supervisor
    import rss_pkg::*;
#(
    parameter int LOSS_CYCLES = LOSS_TIMEOUT_CYC,
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int WDOG_DIV = WDT_DIV,
    parameter int WDOG_LIMIT = WDT_LIMIT
) (
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic CE_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic SFR_WR_I,
    input wire logic [7:0] SFR_WDATA_I,
    output logic [7:0] SFR_RDATA_O,
    input wire logic RST_PIN_I,
    output logic RST_PIN_O,
    output logic RST_PIN_OE_N_O,
    input wire logic SUPPLY_ABOVE_I,
    output logic SUPPLY_MON_EN_O,
    input wire logic SYS_CLOCK_SIGNAL_I,
    output logic SYS_RESET_N_O
);
    localparam int HW = $clog2(HOLD_CYCLES + 1);

    generate
        if (HOLD_CYCLES < 1) begin : g_bad_hold
            $error("rss_supervisor: HOLD_CYCLES must be >= 1");
        end
        if (LOSS_CYCLES < 1 || WDOG_DIV < 2 || WDOG_LIMIT < 1) begin : g_bad_tmr
            $error("rss_supervisor: timer parameters out of range");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Index 0 reset pin, 1 supply comparator, 2 watched clock.
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic clk_prev_reg;

    // The edge detector starts at the synchroniser's reset level, so
    // leaving reset never shows a false watched-clock edge.
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            meta_reg <= 3'h7;
            sync_reg <= 3'h7;
            clk_prev_reg <= 1'b1;
        end else if (CE_I) begin
            meta_reg <= {SYS_CLOCK_SIGNAL_I, SUPPLY_ABOVE_I, RST_PIN_I};
            sync_reg <= meta_reg;
            clk_prev_reg <= sync_reg[2];
        end
    end

    wire pin_s = sync_reg[0];
    wire supply_s = sync_reg[1];
    wire clk_edge = sync_reg[2] ^ clk_prev_reg;

    // ------------------------------------------------------------------
    // State and register storage
    // ------------------------------------------------------------------
    rss_state_t state_reg;
    rss_state_t state_next;
    rss_cause_t cause_reg;
    rss_cause_t cause_next;
    rss_cause_t req_cause;
    logic [HW-1:0] hold_reg;
    logic [HW-1:0] hold_next;
    logic smc_en_reg;
    logic mon_sel_reg;
    logic loss_en_reg;
    logic wdt_en_reg;
    logic wdt_en_next;
    logic [5:0] flags_reg;
    logic [5:0] flags_next;
    logic drive_reg;
    logic [1:0] drive_hist_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // ------------------------------------------------------------------
    // Register port decode
    // ------------------------------------------------------------------
    // The processor is itself in reset while the supervisor holds, so
    // writes are only honoured in the run state.
    wire in_run = (state_reg == ST_RUN);
    wire wr_ok = SFR_WR_I & in_run;
    wire wr_smc = wr_ok & (SFR_ADDR_I == ADDR_SUPPLY_CTRL);
    wire wr_rsr = wr_ok & (SFR_ADDR_I == ADDR_RESET_SRC);
    wire wr_wdc = wr_ok & (SFR_ADDR_I == ADDR_WDT_CTRL);
    wire wdt_kick = wr_wdc & SFR_WDATA_I[WDC_KICK_BIT];

    // ------------------------------------------------------------------
    // Reset requests
    // ------------------------------------------------------------------
    rss_ctl_if ctl ();

    // Our own pin drive reads back low through the synchroniser, so the
    // pin is ignored until that echo has cleared.
    wire pin_masked = drive_reg | (|drive_hist_reg);
    wire req_pin = ~pin_s & ~pin_masked;
    wire req_supply = smc_en_reg & mon_sel_reg & ~supply_s;
    wire req_loss = ctl.loss_fire;
    wire req_wdt = ctl.wdt_fire;
    wire req_soft = wr_rsr & SFR_WDATA_I[RSR_SOFT_BIT];
    wire any_req = req_pin | req_supply | req_loss | req_wdt | req_soft;

    // Supply loss dominates because it also owns the reset pin.
    assign req_cause = req_supply ? CAUSE_SUPPLY :
                       req_pin ? CAUSE_PIN :
                       req_loss ? CAUSE_LOSS :
                       req_wdt ? CAUSE_WDT : CAUSE_SOFT;

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cause_next = cause_reg;
        hold_next = hold_reg;
        flags_next = flags_reg;
        case (state_reg)
            ST_RUN: begin
                if (any_req) begin
                    state_next = ST_HOLD;
                    cause_next = req_cause;
                    hold_next = HW'(HOLD_CYCLES);
                end
            end
            ST_HOLD: begin
                if (any_req) begin
                    cause_next = req_cause;
                    hold_next = HW'(HOLD_CYCLES);
                end else if (hold_reg != '0) begin
                    hold_next = hold_reg - 1'b1;
                end else begin
                    state_next = ST_RUN;
                    flags_next = FLAGS_RESET;
                    case (cause_reg)
                        CAUSE_PIN: flags_next[RSR_PIN_BIT] = 1'b1;
                        CAUSE_LOSS: flags_next[RSR_LOSS_BIT] = 1'b1;
                        CAUSE_WDT: flags_next[RSR_WDT_BIT] = 1'b1;
                        CAUSE_SOFT: flags_next[RSR_SOFT_BIT] = 1'b1;
                        default: flags_next[RSR_POR_BIT] = 1'b1;
                    endcase
                end
            end
            default: begin
                state_next = ST_HOLD;
                hold_next = HW'(HOLD_CYCLES);
            end
        endcase
    end

    // Power-on starts in the hold state so its own flag gets recorded.
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_reg <= ST_HOLD;
            cause_reg <= CAUSE_POWER;
            hold_reg <= HW'(HOLD_CYCLES);
            flags_reg <= FLAGS_RESET;
        end else if (CE_I) begin
            state_reg <= state_next;
            cause_reg <= cause_next;
            hold_reg <= hold_next;
            flags_reg <= flags_next;
        end
    end

    // ------------------------------------------------------------------
    // Reset pin drive
    // ------------------------------------------------------------------
    // Only supply and power-on resets pull the pin; other sources stay
    // internal so parts on the board are not reset with the core.
    wire drive_next = (state_next == ST_HOLD)
                      & ((cause_next == CAUSE_SUPPLY)
                         | (cause_next == CAUSE_POWER));

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            drive_reg <= 1'b1;
            drive_hist_reg <= 2'h3;
        end else if (CE_I) begin
            drive_reg <= drive_next;
            drive_hist_reg <= {drive_hist_reg[0], drive_reg};
        end
    end

    assign RST_PIN_O = 1'b0;
    assign RST_PIN_OE_N_O = ~drive_reg;
    assign SYS_RESET_N_O = in_run;

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    // The monitor enable is only touched by power-on and by software.
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            smc_en_reg <= SMC_EN_RESET;
            mon_sel_reg <= MON_SEL_RESET;
            loss_en_reg <= LOSS_EN_RESET;
        end else if (CE_I) begin
            if (wr_smc) begin
                smc_en_reg <= SFR_WDATA_I[SMC_EN_BIT];
            end
            if (wr_rsr) begin
                mon_sel_reg <= SFR_WDATA_I[RSR_POR_BIT];
                loss_en_reg <= SFR_WDATA_I[RSR_LOSS_BIT];
            end
        end
    end

    // Software must disable the watchdog again after every release.
    assign wdt_en_next = (state_reg == ST_HOLD) ? WDT_EN_RESET :
                         (wr_wdc ? SFR_WDATA_I[WDC_EN_BIT] : wdt_en_reg);

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            wdt_en_reg <= WDT_EN_RESET;
        end else if (CE_I) begin
            wdt_en_reg <= wdt_en_next;
        end
    end

    assign SUPPLY_MON_EN_O = smc_en_reg;

    // ------------------------------------------------------------------
    // Timers
    // ------------------------------------------------------------------
    assign ctl.sys_rst = (state_reg == ST_HOLD);
    assign ctl.wdt_enable = wdt_en_reg;
    assign ctl.wdt_kick = wdt_kick;
    assign ctl.loss_enable = loss_en_reg;
    assign ctl.clk_edge = clk_edge;

    rss_watchdog #(
        .DIV(WDOG_DIV),
        .LIMIT(WDOG_LIMIT)
    ) u_watchdog (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESET_N_I),
        .ce_i(CE_I),
        .ctl(ctl.wdt_mp)
    );

    rss_loss_det #(
        .TIMEOUT(LOSS_CYCLES)
    ) u_loss_det (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESET_N_I),
        .ce_i(CE_I),
        .ctl(ctl.loss_mp)
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Unused monitor bits read as zero; reads have one cycle of latency.
    wire [7:0] rd_smc = {smc_en_reg, supply_s, 6'h00};
    wire [7:0] rd_rsr = {2'h0, flags_reg};
    wire [7:0] rd_wdc = {7'h00, wdt_en_reg};

    assign rdata_next = (SFR_ADDR_I == ADDR_SUPPLY_CTRL) ? rd_smc :
                        (SFR_ADDR_I == ADDR_RESET_SRC) ? rd_rsr :
                        (SFR_ADDR_I == ADDR_WDT_CTRL) ? rd_wdc : RD_ZERO;

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rdata_reg <= RD_ZERO;
        end else if (CE_I) begin
            rdata_reg <= rdata_next;
        end
    end

    assign SFR_RDATA_O = rdata_reg;

endmodule : rss_supervisor

// ==== rtl/rss_watchdog.sv ====
// Watchdog counter clocked by the system clock divided down.
// Assumes the owner clears it through sys_rst during every internal reset.
module rss_watchdog
    import rss_pkg::*;
#(
    parameter int DIV = WDT_DIV,
    parameter int LIMIT = WDT_LIMIT
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    rss_ctl_if.wdt_mp ctl
);
    localparam int PW = $clog2(DIV);
    localparam int CW = $clog2(LIMIT + 1);

    generate
        if (DIV < 2 || LIMIT < 1) begin : g_bad
            $error("rss_watchdog: DIV must be >= 2 and LIMIT >= 1");
        end
    endgenerate

    logic [PW-1:0] pre_reg;
    logic [PW-1:0] pre_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;
    logic fire_reg;
    wire tick = (pre_reg == PW'(DIV - 1));
    // A kick, a disable or an internal reset restarts the full interval.
    wire hold = ctl.sys_rst | ~ctl.wdt_enable | ctl.wdt_kick;
    wire at_limit = (cnt_reg == CW'(LIMIT));

    assign pre_next = (hold | tick) ? '0 : pre_reg + 1'b1;
    assign cnt_next = hold ? '0 : ((tick & ~at_limit) ? cnt_reg + 1'b1
                                                       : cnt_reg);
    assign ctl.wdt_fire = fire_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_reg <= '0;
            cnt_reg <= '0;
            fire_reg <= 1'b0;
        end else if (ce_i) begin
            pre_reg <= pre_next;
            cnt_reg <= cnt_next;
            fire_reg <= ~hold & (cnt_next == CW'(LIMIT));
        end
    end
endmodule : rss_watchdog

// ==== verification/reset_source_supervisor_bench.sv ====
// Self-checking bench for the reset source supervisor.
// Assumes the pin model and the bound checker are compiled alongside.
module reset_source_supervisor_bench
    import rss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0, rst_n, ce, wr_en, ext_low, supply, run;
    logic [7:0] addr, wdata, rdata, d;
    logic pin_lvl, pin_o, oe_n, clk_sig, mon_en, sys_rst_n;
    int error_cnt = 0;
    int comparisons = 0;

    always #25 clk_sys = ~clk_sys;

    rss_supervisor #(.LOSS_CYCLES(10), .HOLD_CYCLES(4), .WDOG_DIV(12),
        .WDOG_LIMIT(3)) u_rss_supervisor (.CLK_SYS_I(clk_sys),
        .RESET_N_I(rst_n), .CE_I(ce), .SFR_ADDR_I(addr), .SFR_WR_I(wr_en),
        .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata), .RST_PIN_I(pin_lvl),
        .RST_PIN_O(pin_o), .RST_PIN_OE_N_O(oe_n), .SUPPLY_ABOVE_I(supply),
        .SUPPLY_MON_EN_O(mon_en), .SYS_CLOCK_SIGNAL_I(clk_sig),
        .SYS_RESET_N_O(sys_rst_n));
    rss_pin_model u_rss_pin_model (.ext_low_i(ext_low), .pin_o_i(pin_o),
        .oe_n_i(oe_n), .run_i(run), .pin_lvl_o(pin_lvl),
        .clk_sig_o(clk_sig));

    // ----
    // Access and check tasks
    // ----
    task automatic chk(input string what, input logic [7:0] got,
                       input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        addr <= a;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        v = rdata;
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // Bounded wait so a stuck reset shows as a mismatch, not a hang.
    task automatic wait_rst(input logic lvl);
        int n;
        n = 0;
        while (sys_rst_n !== lvl && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        chk("reset level", {7'h00, sys_rst_n}, {7'h00, lvl});
    endtask : wait_rst

    task automatic settle(input string name, input logic [7:0] flags);
        logic [7:0] v;
        wait_rst(1'b1);
        rd(ADDR_RESET_SRC, v);
        chk("source flags", v, flags);
        rd(ADDR_WDT_CTRL, v);
        chk("watchdog enable", {7'h00, v[0]}, 8'h01);
        wr(ADDR_WDT_CTRL, 8'h00);
        $display("test %s done", name);
    endtask : settle

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results

    // ----
    // Test sequence
    // ----
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        wr_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        ext_low = 1'b0;
        supply = 1'b1;
        run = 1'b1;
        cyc(3);
        rst_n <= 1'b1;
        settle("power-on", 8'h02);
        wr(ADDR_SUPPLY_CTRL, 8'h3F);
        rd(ADDR_SUPPLY_CTRL, d);
        chk("monitor ctl", d, 8'h40);
        chk("monitor enable", {7'h00, mon_en}, 8'h00);
        @(posedge clk_sys) supply <= 1'b0;
        cyc(12);
        rd(ADDR_SUPPLY_CTRL, d);
        chk("status low", d, 8'h00);
        chk("disabled monitor", {7'h00, sys_rst_n}, 8'h01);
        @(posedge clk_sys) supply <= 1'b1;
        wr(ADDR_RESET_SRC, 8'h10);
        wait_rst(1'b0);
        settle("software", 8'h10);
        rd(ADDR_SUPPLY_CTRL, d);
        chk("enable kept", d, 8'h40);
        @(posedge clk_sys) ce <= 1'b0;
        wr(ADDR_SUPPLY_CTRL, 8'h80);
        ce <= 1'b1;
        rd(ADDR_SUPPLY_CTRL, d);
        chk("frozen write", d, 8'h40);
        wr(ADDR_SUPPLY_CTRL, 8'h80);
        cyc(20);
        wr(ADDR_RESET_SRC, 8'h02);
        @(posedge clk_sys) supply <= 1'b0;
        wait_rst(1'b0);
        cyc(20);
        @(negedge clk_sys);
        chk("pin driven", {7'h00, pin_lvl}, 8'h00);
        @(posedge clk_sys) supply <= 1'b1;
        settle("supply", 8'h02);
        @(posedge clk_sys) ext_low <= 1'b1;
        wait_rst(1'b0);
        cyc(8);
        @(posedge clk_sys) ext_low <= 1'b0;
        settle("pin", 8'h01);
        wr(ADDR_RESET_SRC, 8'h06);
        cyc(40);
        chk("clock running", {7'h00, sys_rst_n}, 8'h01);
        @(posedge clk_sys) run <= 1'b0;
        wait_rst(1'b0);
        chk("pin idle", {7'h00, pin_lvl}, 8'h01);
        cyc(5);
        @(posedge clk_sys) run <= 1'b1;
        settle("clock loss", 8'h04);
        wr(ADDR_RESET_SRC, 8'h02);
        @(posedge clk_sys) run <= 1'b0;
        cyc(40);
        chk("detector off", {7'h00, sys_rst_n}, 8'h01);
        @(posedge clk_sys) run <= 1'b1;
        wr(ADDR_WDT_CTRL, 8'h01);
        repeat (4) begin
            cyc(20);
            wr(ADDR_WDT_CTRL, 8'h03);
        end
        chk("kicked", {7'h00, sys_rst_n}, 8'h01);
        wait_rst(1'b0);
        chk("pin idle", {7'h00, pin_lvl}, 8'h01);
        settle("watchdog", 8'h20);
        rd(8'h10, d);
        chk("unmapped", d, 8'h00);
        wr(ADDR_SUPPLY_CTRL, 8'h00);
        @(posedge clk_sys) rst_n <= 1'b0;
        cyc(2);
        rst_n <= 1'b1;
        settle("power-on again", 8'h02);
        rd(ADDR_SUPPLY_CTRL, d);
        chk("enable on power-on", d, 8'hC0);
        results();
    end

    initial begin
        cyc(5000);
        error_cnt++;
        results();
    end
endmodule : reset_source_supervisor_bench

// ==== verification/rss_pin_model.sv ====
// External reset circuitry: pulled-up reset pin and the watched clock.
// Assumes the bench decides when the pin is pulled and the clock stops.
module rss_pin_model (
    input wire logic ext_low_i,
    input wire logic pin_o_i,
    input wire logic oe_n_i,
    input wire logic run_i,
    output logic pin_lvl_o,
    output logic clk_sig_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_q = 1'b0;
    // Open drain with pull-up: low if either party pulls it.
    assign pin_lvl_o = ~(ext_low_i || (!oe_n_i && !pin_o_i));
    assign clk_sig_o = clk_q;
    // Period unrelated to the system clock; stands still when stopped.
    always begin
        #65;
        if (run_i) clk_q = ~clk_q;
    end
endmodule : rss_pin_model

// ==== verification/rss_supervisor_chk.sv ====
// Port-level checker for the reset source supervisor.
// Assumes CE_I only drops while timers idle; monitor selected when enabled.
module rss_chk
    import rss_pkg::*;
#(
    parameter int LOSS_CYCLES = LOSS_TIMEOUT_CYC,
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int WDOG_DIV = WDT_DIV,
    parameter int WDOG_LIMIT = WDT_LIMIT
) (
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic CE_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic SFR_WR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic [7:0] SFR_RDATA_O,
    input wire logic RST_PIN_I,
    input wire logic RST_PIN_OE_N_O,
    input wire logic SUPPLY_ABOVE_I,
    input wire logic SUPPLY_MON_EN_O,
    input wire logic SYS_CLOCK_SIGNAL_I,
    input wire logic SYS_RESET_N_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);

    // ----
    // Helper logic
    // ----
    // Watchdog bound allows one prescaler period of phase slack.
    localparam int WDT_MAX = WDOG_LIMIT * WDOG_DIV + WDOG_DIV + 4;
    wire wr_ok = CE_I && SFR_WR_I && SYS_RESET_N_O;
    wire wr_smc = wr_ok && SFR_ADDR_I == ADDR_SUPPLY_CTRL;
    wire wr_src = wr_ok && SFR_ADDR_I == ADDR_RESET_SRC;
    wire wr_wdc = wr_ok && SFR_ADDR_I == ADDR_WDT_CTRL;
    logic wdt_en_reg, loss_en_reg, clk_q_reg;
    logic [9:0] wdt_cnt_reg;
    logic [7:0] stuck_cnt_reg, hold_cnt_reg;

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            wdt_en_reg <= 1'b1;
            loss_en_reg <= 1'b0;
            clk_q_reg <= 1'b0;
            wdt_cnt_reg <= 10'h000;
            stuck_cnt_reg <= 8'h00;
            hold_cnt_reg <= 8'h00;
        end else begin
            clk_q_reg <= SYS_CLOCK_SIGNAL_I;
            hold_cnt_reg <= SYS_RESET_N_O ? 8'h00 : hold_cnt_reg + 8'h01;
            if (wr_src) loss_en_reg <= SFR_WDATA_I[RSR_LOSS_BIT];
            if (!SYS_RESET_N_O) wdt_en_reg <= 1'b1;
            else if (wr_wdc) wdt_en_reg <= SFR_WDATA_I[WDC_EN_BIT];
            if (!SYS_RESET_N_O || wr_wdc || !wdt_en_reg)
                wdt_cnt_reg <= 10'h000;
            else wdt_cnt_reg <= wdt_cnt_reg + 10'h001;
            if (clk_q_reg != SYS_CLOCK_SIGNAL_I || !loss_en_reg || wr_src)
                stuck_cnt_reg <= 8'h00;
            else if (stuck_cnt_reg != 8'hFF)
                stuck_cnt_reg <= stuck_cnt_reg + 8'h01;
        end
    end

    // ----
    // Sequences and assertions
    // ----
    sequence s_rd_ctl;
        (SYS_RESET_N_O && !SFR_WR_I && SFR_ADDR_I == ADDR_SUPPLY_CTRL)[*2];
    endsequence
    sequence s_pin_low;
        (RST_PIN_OE_N_O && !RST_PIN_I)[*4];
    endsequence
    sequence s_supply_low;
        (!SUPPLY_ABOVE_I && SUPPLY_MON_EN_O)[*4];
    endsequence

    a_mon_en_wr: assert property (wr_smc |=>
        SUPPLY_MON_EN_O == $past(SFR_WDATA_I[SMC_EN_BIT]))
        else $error("monitor enable does not follow write");
    a_mon_en_keep: assert property (
        !wr_smc |=> $stable(SUPPLY_MON_EN_O))
        else $error("monitor enable changed without write");
    a_ctl_read: assert property (s_rd_ctl |-> SFR_RDATA_O[5:0] == 6'h00
        && SFR_RDATA_O[SMC_EN_BIT] == SUPPLY_MON_EN_O)
        else $error("monitor control read wrong");
    a_pin_request: assert property (
        s_pin_low |-> ##[0:4] !SYS_RESET_N_O)
        else $error("low reset pin gave no reset");
    a_supply_reset: assert property (s_supply_low |-> ##[0:2]
        (!SYS_RESET_N_O && !RST_PIN_OE_N_O))
        else $error("low supply gave no pin-driving reset");
    a_drive_in_reset: assert property (
        !RST_PIN_OE_N_O |-> !SYS_RESET_N_O)
        else $error("pin driven outside reset");
    a_no_pin_drive: assert property (
        (SYS_RESET_N_O && SUPPLY_ABOVE_I)[*4] |=> RST_PIN_OE_N_O)
        else $error("pin driven for internal reset");
    a_hold_length: assert property ($rose(SYS_RESET_N_O) |->
        $past(hold_cnt_reg) >= HOLD_CYCLES)
        else $error("reset released too early");
    a_wdt_bound: assert property (
        SYS_RESET_N_O |-> wdt_cnt_reg <= WDT_MAX)
        else $error("watchdog did not reset in time");
    a_loss_fire: assert property (stuck_cnt_reg >= LOSS_CYCLES + 5 |->
        !SYS_RESET_N_O)
        else $error("stopped clock gave no reset");
endmodule : rss_chk

bind rss_supervisor rss_chk #(.LOSS_CYCLES(LOSS_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES), .WDOG_DIV(WDOG_DIV),
    .WDOG_LIMIT(WDOG_LIMIT)) u_rss_chk (.CLK_SYS_I(CLK_SYS_I),
    .RESET_N_I(RESET_N_I), .CE_I(CE_I), .SFR_ADDR_I(SFR_ADDR_I),
    .SFR_WR_I(SFR_WR_I), .SFR_WDATA_I(SFR_WDATA_I),
    .SFR_RDATA_O(SFR_RDATA_O), .RST_PIN_I(RST_PIN_I),
    .RST_PIN_OE_N_O(RST_PIN_OE_N_O), .SUPPLY_ABOVE_I(SUPPLY_ABOVE_I),
    .SUPPLY_MON_EN_O(SUPPLY_MON_EN_O),
    .SYS_CLOCK_SIGNAL_I(SYS_CLOCK_SIGNAL_I),
    .SYS_RESET_N_O(SYS_RESET_N_O));
